// >>> verilog/afbp_device.sv
// Purpose: Device end of the parallel FIFO / bit-bang port.
// Assumes: Strobes are synchronous to clk_sys; one-byte rx and tx holds.
// Notes: Flags read high (released) while in reset.
//
// Summary of operation
// - Data bus input unless read strobe low (FIFO) or any bb_dir bit set (bit-bang).
// - Receive flag low when byte readable.
// - Read strobe rise always raises receive flag.
// - Flags undriven during reset.
// - Transmit flag low when write allowed.
// - External never writes while transmit flag high.
// - Read strobe fall presents receive byte.
// - Read strobe rise advances receive byte.
// - Write strobe fall captures bus byte.
// - FIFO operation only when config selects.
// - Suspended wake strobe requests resume when remote wakeup is enabled.
// - Active flush strobe sends buffered data.
// - Unused flush input held high.
// - Bit-bang makes pins bidirectional bus.
// - Pulse pins-updated low on host write.
// - Pins-sampled rises after host read.
`timescale 1ns/10ps
`include "afbp_consts.svh"
module afbp_device
  import afbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  afbp_if.dev pins,
  input wire logic cfg_fifo_mode, // Configuration memory selects FIFO.
  input wire logic bb_enable, // Host command selects bit-bang.
  input wire logic susp, // Suspend flag, 1 when suspended.
  input wire logic wake_en, // Remote wakeup enabled.
  input wire logic rx_valid, // Byte offered from USB side.
  input wire logic [7:0] rx_byte, // Byte from USB side.
  output logic rx_ready, // Offered byte taken.
  output logic tx_valid, // Captured byte available to USB side.
  output logic [7:0] tx_byte, // Captured byte.
  input wire logic tx_take, // USB side takes the captured byte.
  output logic resume_req, // One-cycle resume request.
  output logic flush_req, // One-cycle send-immediate request.
  input wire logic bb_wr_stb, // Host writes new pin data.
  input wire logic [7:0] bb_wr_data, // New pin data.
  input wire logic [7:0] bb_dir, // Pin direction; any 1 bit drives all pins.
  input wire logic bb_rd_stb, // Host samples the pins.
  output logic [7:0] bb_rd_data // Sampled pin data.
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  afbp_mode_t mode_reg, mode_next; // Current pin mode.
  logic [7:0] rxb_reg, rxb_next; // Receive hold byte.
  logic rxf_reg, rxf_next; // Receive hold full.
  logic [7:0] txb_reg, txb_next; // Transmit hold byte.
  logic txf_reg, txf_next; // Transmit hold full.
  logic rd_d_reg, wr_d_reg, fw_d_reg; // Strobe history.
  logic rd_d_next, wr_d_next, fw_d_next;
  logic [7:0] dout_reg, dout_next; // Bus drive value.
  logic doe_n_reg, doe_n_next; // Bus drive enable, low drives.
  logic rxa_n_reg, rxa_n_next; // Receive flag.
  logic txs_n_reg, txs_n_next; // Transmit flag.
  logic foe_n_reg, foe_n_next; // Flag drive enable.
  logic rdy_reg, rdy_next;
  logic res_reg, res_next, fl_reg, fl_next;
  logic [3:0] upd_reg, upd_next; // Pins-updated pulse counter.
  logic upd_n_reg, upd_n_next, smp_reg, smp_next;
  logic [7:0] bbr_reg, bbr_next;
  logic rd_fall, rd_rise, wr_fall, fw_fall;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Edges of the external strobes, and all transfer bookkeeping.
  always_comb begin
    rd_fall = rd_d_reg && !pins.rd_n;
    rd_rise = !rd_d_reg && pins.rd_n;
    wr_fall = wr_d_reg && !pins.wr_n;
    fw_fall = fw_d_reg && !pins.flush_wake_n;
    rd_d_next = pins.rd_n;
    wr_d_next = pins.wr_n;
    fw_d_next = pins.flush_wake_n;
    // Bit-bang wins over FIFO when both are selected.
    if (bb_enable) begin
      mode_next = AFBP_MODE_BB;
    end else if (cfg_fifo_mode) begin
      mode_next = AFBP_MODE_FIFO;
    end else begin
      mode_next = AFBP_MODE_OFF;
    end
    rxb_next = rxb_reg;
    rxf_next = rxf_reg;
    txb_next = txb_reg;
    txf_next = txf_reg;
    rdy_next = 1'b0;
    res_next = 1'b0;
    fl_next = 1'b0;
    dout_next = dout_reg;
    doe_n_next = 1'b1;
    upd_next = upd_reg;
    upd_n_next = 1'b1;
    smp_next = smp_reg;
    bbr_next = bbr_reg;
    foe_n_next = 1'b0;
    if (mode_reg == AFBP_MODE_FIFO) begin
      // Refill the receive hold only while the strobe is high.
      if (!rxf_reg && rx_valid && pins.rd_n && !rd_rise) begin
        rxb_next = rx_byte;
        rxf_next = 1'b1;
        rdy_next = 1'b1;
      end
      if (rd_rise) begin
        rxf_next = 1'b0;
      end
      // Drive the held byte only while the read strobe is low.
      doe_n_next = pins.rd_n;
      if (rd_fall) begin
        dout_next = rxb_reg;
      end
      // Flag is high on the rise, low later if a byte is held.
      // Following the registered hold keeps it high two cycles.
      rxa_n_next = !(rxf_reg && pins.rd_n && !rd_rise);
      // A write fall in the cycle that takes a full hold is not captured; the hold ends empty.
      if (tx_take) begin
        txf_next = 1'b0;
      end
      if (wr_fall && !txf_reg) begin
        txb_next = pins.port_data;
        txf_next = 1'b1;
      end
      txs_n_next = txf_next;
      if (fw_fall) begin
        res_next = susp && wake_en;
        fl_next = !susp;
      end
    end else begin
      rxa_n_next = 1'b1;
      txs_n_next = 1'b1;
      if (tx_take) begin
        txf_next = 1'b0;
      end
    end
    if (mode_reg == AFBP_MODE_BB) begin
      // Host writes drive all pins when any direction bit is set.
      doe_n_next = ~|bb_dir;
      if (bb_wr_stb) begin
        dout_next = bb_wr_data;
        upd_next = `AFBP_UPD_CYC;
      end else if (upd_reg != 4'h0) begin
        upd_next = upd_reg - 4'h1;
      end
      upd_n_next = !(bb_wr_stb || upd_reg > 4'h1);
      // Sample and raise the sampled output on the same edge.
      smp_next = 1'b0;
      if (bb_rd_stb) begin
        bbr_next = pins.port_data;
        smp_next = 1'b1;
      end
    end else begin
      smp_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Flags are released and the bus is input while in reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_reg <= AFBP_MODE_OFF;
      rxb_reg <= `AFBP_DATA_RST;
      rxf_reg <= 1'b0;
      txb_reg <= `AFBP_DATA_RST;
      txf_reg <= 1'b0;
      rd_d_reg <= 1'b1;
      wr_d_reg <= 1'b1;
      fw_d_reg <= 1'b1;
      dout_reg <= `AFBP_DATA_RST;
      doe_n_reg <= 1'b1;
      rxa_n_reg <= 1'b1;
      txs_n_reg <= 1'b1;
      foe_n_reg <= 1'b1;
      rdy_reg <= 1'b0;
      res_reg <= 1'b0;
      fl_reg <= 1'b0;
      upd_reg <= 4'h0;
      upd_n_reg <= 1'b1;
      smp_reg <= 1'b0;
      bbr_reg <= `AFBP_DATA_RST;
    end else begin
      mode_reg <= mode_next;
      rxb_reg <= rxb_next;
      rxf_reg <= rxf_next;
      txb_reg <= txb_next;
      txf_reg <= txf_next;
      rd_d_reg <= rd_d_next;
      wr_d_reg <= wr_d_next;
      fw_d_reg <= fw_d_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      rxa_n_reg <= rxa_n_next;
      txs_n_reg <= txs_n_next;
      foe_n_reg <= foe_n_next;
      rdy_reg <= rdy_next;
      res_reg <= res_next;
      fl_reg <= fl_next;
      upd_reg <= upd_next;
      upd_n_reg <= upd_n_next;
      smp_reg <= smp_next;
      bbr_reg <= bbr_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pins.dev_data_o = dout_reg;
  assign pins.dev_data_oe_n = doe_n_reg;
  assign pins.rx_avail_n = rxa_n_reg;
  assign pins.tx_space_n = txs_n_reg;
  assign pins.flag_oe_n = foe_n_reg;
  assign pins.pins_updated_n = upd_n_reg;
  assign pins.pins_sampled = smp_reg;
  assign rx_ready = rdy_reg;
  assign tx_valid = txf_reg;
  assign tx_byte = txb_reg;
  assign resume_req = res_reg;
  assign flush_req = fl_reg;
  assign bb_rd_data = bbr_reg;
endmodule

// >>> include/afbp_consts.svh
// Purpose: Shared constants for the parallel FIFO / bit-bang port.
// Assumes: One 100 MHz system clock on both ends.
// Notes: Counts are in clk_sys cycles.
`ifndef AFBP_CONSTS_SVH
`define AFBP_CONSTS_SVH
// ----------------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------------
`define AFBP_DATA_W 8
`define AFBP_CLK_NS 10
// Least strobe low time, in ns, and derived cycle count (rounded up).
`define AFBP_STB_NS 30
`define AFBP_STB_CYC ((`AFBP_STB_NS + `AFBP_CLK_NS - 1) / `AFBP_CLK_NS)
// Length of the pins-updated low pulse, in cycles.
`define AFBP_UPD_CYC 4'h2
// Data reset value.
`define AFBP_DATA_RST 8'h00
`endif

// >>> include/afbp_pkg.sv
// Purpose: Types for the parallel FIFO / bit-bang port.
// Assumes: Included constants header.
// Notes: Mode selects async FIFO or bit-bang pin use.
package afbp_pkg;
  // Port operating mode.
  typedef enum logic [1:0] {
    AFBP_MODE_OFF = 2'b00,
    AFBP_MODE_FIFO = 2'b01,
    AFBP_MODE_BB = 2'b10
  } afbp_mode_t;
  // Host end sequencer states.
  typedef enum logic [2:0] {
    AFBP_H_IDLE = 3'b000,
    AFBP_H_RD_LO = 3'b001,
    AFBP_H_RD_HI = 3'b010,
    AFBP_H_WR_HI = 3'b011,
    AFBP_H_WR_LO = 3'b100
  } afbp_hstate_t;
endpackage

// >>> include/afbp_if.sv
// Purpose: Pin bundle joining the device end and the external end.
// Assumes: Both ends clocked by clk_sys.
// Notes: Bus level is resolved here from the two output enables.
`timescale 1ns/10ps
interface afbp_if;
  logic [7:0] dev_data_o; // Device drive value.
  logic dev_data_oe_n; // Device drive enable, low drives.
  logic [7:0] ext_data_o; // External drive value.
  logic ext_data_oe_n; // External drive enable, low drives.
  logic [7:0] port_data; // Resolved bus level.
  logic rx_avail_n; // Receive byte available, low active.
  logic tx_space_n; // Transmit space, low active.
  logic flag_oe_n; // Flag drive enable, low drives.
  logic rd_n; // Read strobe from external party.
  logic wr_n; // Write strobe from external party.
  logic flush_wake_n; // Flush or wake strobe.
  logic pins_updated_n; // Bit-bang new data pulse.
  logic pins_sampled; // Bit-bang sample edge.
  // Pull-up resolution of the data bus only.
  assign port_data = !dev_data_oe_n ? dev_data_o :
                     (!ext_data_oe_n ? ext_data_o : 8'hFF);
  modport dev (
    output dev_data_o, dev_data_oe_n, rx_avail_n, tx_space_n, flag_oe_n,
    output pins_updated_n, pins_sampled,
    input port_data, rd_n, wr_n, flush_wake_n
  );
  modport ext (
    output ext_data_o, ext_data_oe_n, rd_n, wr_n, flush_wake_n,
    input port_data, rx_avail_n, tx_space_n, flag_oe_n,
    input pins_updated_n, pins_sampled
  );
endinterface

// >>> verilog/afbp_external.sv
// Purpose: External controller end driving the parallel FIFO strobes.
// Assumes: Flags and data are synchronous to clk_sys.
// Notes: One read or one write per request; never both at once.
`timescale 1ns/10ps
`include "afbp_consts.svh"
module afbp_external
  import afbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  afbp_if.ext pins,
  input wire logic rd_req, // Request one byte read.
  input wire logic wr_req, // Request one byte write.
  input wire logic [7:0] wr_byte, // Byte to write.
  input wire logic flush_req, // Request one flush/wake strobe.
  output logic busy, // Sequencer active.
  output logic rd_done, // One-cycle read completion.
  output logic [7:0] rd_byte // Byte read.
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  afbp_hstate_t st_reg, st_next; // Strobe sequencer.
  logic [3:0] cnt_reg, cnt_next; // Strobe width counter.
  logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
  logic fw_n_reg, fw_n_next;
  logic [7:0] dout_reg, dout_next;
  logic doe_n_reg, doe_n_next;
  logic done_reg, done_next;
  logic [7:0] rdb_reg, rdb_next;
  logic busy_reg, busy_next; // Sequencer active, from a flip-flop.

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Reads wait for the receive flag, writes for the transmit flag.
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    fw_n_next = !flush_req;
    dout_next = dout_reg;
    doe_n_next = doe_n_reg;
    done_next = 1'b0;
    rdb_next = rdb_reg;
    unique case (st_reg)
      AFBP_H_IDLE: begin
        // Flags are ignored while their drive is released.
        if (rd_req && !pins.flag_oe_n && !pins.rx_avail_n) begin
          st_next = AFBP_H_RD_LO;
          rd_n_next = 1'b0;
          cnt_next = 4'(`AFBP_STB_CYC);
        end else if (wr_req && !pins.flag_oe_n && !pins.tx_space_n) begin
          st_next = AFBP_H_WR_HI;
          dout_next = wr_byte;
          doe_n_next = 1'b0;
          wr_n_next = 1'b1;
          cnt_next = 4'(`AFBP_STB_CYC);
        end
      end
      AFBP_H_RD_LO: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else begin
          rdb_next = pins.port_data;
          rd_n_next = 1'b1;
          done_next = 1'b1;
          st_next = AFBP_H_RD_HI;
          cnt_next = 4'(`AFBP_STB_CYC);
        end
      end
      AFBP_H_RD_HI: begin
        // Let the receive flag settle before the next request.
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else begin
          st_next = AFBP_H_IDLE;
        end
      end
      AFBP_H_WR_HI: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else begin
          wr_n_next = 1'b0;
          st_next = AFBP_H_WR_LO;
          cnt_next = 4'(`AFBP_STB_CYC);
        end
      end
      AFBP_H_WR_LO: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else begin
          wr_n_next = 1'b1;
          doe_n_next = 1'b1;
          st_next = AFBP_H_RD_HI;
          cnt_next = 4'(`AFBP_STB_CYC);
        end
      end
      default: begin
        st_next = AFBP_H_IDLE;
      end
    endcase
    // Busy follows the state that the next edge will load.
    busy_next = (st_next != AFBP_H_IDLE);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Strobes idle high and the bus is released in reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= AFBP_H_IDLE;
      cnt_reg <= 4'h0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      fw_n_reg <= 1'b1;
      dout_reg <= `AFBP_DATA_RST;
      doe_n_reg <= 1'b1;
      done_reg <= 1'b0;
      rdb_reg <= `AFBP_DATA_RST;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      fw_n_reg <= fw_n_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      done_reg <= done_next;
      rdb_reg <= rdb_next;
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pins.rd_n = rd_n_reg;
  assign pins.wr_n = wr_n_reg;
  assign pins.flush_wake_n = fw_n_reg;
  assign pins.ext_data_o = dout_reg;
  assign pins.ext_data_oe_n = doe_n_reg;
  assign busy = busy_reg;
  assign rd_done = done_reg;
  assign rd_byte = rdb_reg;
endmodule

// >>> verification/afbp_port_chk.sv
// Purpose: Pin-level checks on the link between the two port ends.
// Assumes: Every pin is sampled on clk_sys; rst is active high.
// Notes: Takes the interface signals as plain inputs.
`timescale 1ns/10ps
module afbp_port_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic dev_data_oe_n,
  input wire logic rx_avail_n,
  input wire logic tx_space_n,
  input wire logic flag_oe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic pins_updated_n,
  input wire logic pins_sampled
);
  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  // All checks share one domain; all but float_in_reset_a stop while reset holds.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Flags float to the pull-up level for the whole reset.
  float_in_reset_a: assert property (
    disable iff (1'b0) rst |-> flag_oe_n && rx_avail_n && tx_space_n)
    else $error("Flags are driven during reset.");
  // A falling read strobe makes the device drive the bus.
  read_drive_a: assert property ($fell(rd_n) |=> !dev_data_oe_n)
    else $error("Bus not driven after read strobe fell.");
  // The bus is let go one cycle after the read strobe rises.
  read_release_a: assert property ($rose(rd_n) |=> dev_data_oe_n)
    else $error("Bus still driven after read strobe rose.");
  // The receive flag goes high and stays so for two cycles.
  rx_flag_up_a: assert property (
    $rose(rd_n) |=> rx_avail_n [*2])
    else $error("Receive flag not raised after a read.");
  // A read begins only while the receive flag is low.
  read_allowed_a: assert property (
    $fell(rd_n) |-> !$past(rx_avail_n))
    else $error("Read started with receive flag high.");
  // A captured byte fills the hold and raises the space flag.
  tx_full_a: assert property ($fell(wr_n) |=> tx_space_n)
    else $error("Space flag low after a write.");
  // A write begins only while the space flag is low.
  write_allowed_a: assert property (
    $fell(wr_n) |-> !$past(tx_space_n))
    else $error("Write started with space flag high.");
  // Write never overlaps a read or the device driving the bus.
  no_overlap_a: assert property (
    !wr_n |-> rd_n && dev_data_oe_n)
    else $error("Write overlaps a read.");
  // The pins-updated pulse lasts exactly two cycles.
  upd_pulse_a: assert property (
    $fell(pins_updated_n) |=> !pins_updated_n ##1 pins_updated_n)
    else $error("Pins-updated pulse has the wrong length.");
  // The pins-sampled pulse is high for a single cycle.
  smp_pulse_a: assert property (
    $rose(pins_sampled) |=> !pins_sampled)
    else $error("Pins-sampled pulse too long.");
endmodule

// >>> verification/tb_async_fifo_bitbang_port.sv
// Purpose: Self-checking bench joining the device and external ends.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes: The external end performs every FIFO pin-level transfer.
`timescale 1ns/10ps
module tb_async_fifo_bitbang_port;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst; // Raised at time zero so the reset edge is seen.
  logic cfg_fifo_mode = 1'b0, bb_enable = 1'b0, susp = 1'b0;
  logic wake_en = 1'b0, rx_valid = 1'b0, tx_take = 1'b0;
  logic bb_wr_stb = 1'b0, bb_rd_stb = 1'b0;
  logic [7:0] rx_byte = 8'h00, bb_wr_data = 8'h00, bb_dir = 8'h00;
  logic rd_req = 1'b0, wr_req = 1'b0, ext_flush_req = 1'b0;
  logic [7:0] wr_byte = 8'h00;
  logic rx_ready, tx_valid, resume_req, dev_flush_req, busy, rd_done;
  logic [7:0] tx_byte, bb_rd_data, rd_byte;
  logic seen; // Pulse seen during a watch window.
  int failures = 0, comparisons = 0, cycles = 0, fills = 0;
  afbp_if pins_if();
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  afbp_device i_afbp_device (.clk_sys(clk_sys), .rst(rst),
    .pins(pins_if), .cfg_fifo_mode(cfg_fifo_mode), .bb_enable(bb_enable),
    .susp(susp), .wake_en(wake_en), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_take(tx_take), .resume_req(resume_req),
    .flush_req(dev_flush_req), .bb_wr_stb(bb_wr_stb),
    .bb_wr_data(bb_wr_data), .bb_dir(bb_dir), .bb_rd_stb(bb_rd_stb),
    .bb_rd_data(bb_rd_data));
  afbp_external i_afbp_external (.clk_sys(clk_sys), .rst(rst),
    .pins(pins_if), .rd_req(rd_req), .wr_req(wr_req), .wr_byte(wr_byte),
    .flush_req(ext_flush_req), .busy(busy), .rd_done(rd_done),
    .rd_byte(rd_byte));
  afbp_port_chk i_afbp_port_chk (.clk_sys(clk_sys), .rst(rst),
    .dev_data_oe_n(pins_if.dev_data_oe_n), .rx_avail_n(pins_if.rx_avail_n),
    .tx_space_n(pins_if.tx_space_n), .flag_oe_n(pins_if.flag_oe_n),
    .rd_n(pins_if.rd_n), .wr_n(pins_if.wr_n),
    .pins_updated_n(pins_if.pins_updated_n),
    .pins_sampled(pins_if.pins_sampled));
  // Clock of 10 ns period.
  always #5 clk_sys = ~clk_sys;
  // Run ceiling: all tests need well under 1000 cycles.
  // Also counts bytes taken into the receive hold.
  always @(posedge clk_sys) begin
    cycles++;
    if (rx_ready === 1'b1) begin
      fills++;
    end
    if (cycles == 4000) begin
      failures++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compares a seen value with the expected one.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Waits until the external sequencer is idle again.
  task automatic wait_idle;
    do @(posedge clk_sys); while (busy !== 1'b0);
  endtask
  // Offers a byte until the receive flag shows it is readable.
  task automatic offer(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_byte <= b;
    do @(posedge clk_sys); while (pins_if.rx_avail_n !== 1'b0);
    rx_valid <= 1'b0;
  endtask
  // Reads one byte across the pins and compares it.
  task automatic fetch(input logic [7:0] exp);
    rd_req <= 1'b1;
    do @(posedge clk_sys); while (rd_done !== 1'b1);
    rd_req <= 1'b0;
    check(rd_byte, exp);
    wait_idle();
  endtask
  // Writes one byte across the pins.
  task automatic send(input logic [7:0] b);
    wr_req <= 1'b1;
    wr_byte <= b;
    do @(posedge clk_sys); while (busy !== 1'b1);
    wr_req <= 1'b0;
    wait_idle();
  endtask
  // Strobes flush/wake and gathers the resume and flush pulses.
  task automatic strobe(input logic s, input logic w, input logic [1:0] e);
    logic [1:0] got;
    got = 2'b00;
    susp <= s;
    wake_en <= w;
    ext_flush_req <= 1'b1;
    @(posedge clk_sys);
    ext_flush_req <= 1'b0;
    repeat (12) begin
      @(posedge clk_sys);
      got = got | {resume_req, dev_flush_req};
    end
    check({6'h00, got}, {6'h00, e});
    wait_idle();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    // Outside FIFO mode a waiting byte must not show on the flags.
    rx_valid <= 1'b1;
    rx_byte <= 8'hA5;
    repeat (6) @(posedge clk_sys);
    check({7'h00, pins_if.rx_avail_n}, 8'h01);
    cfg_fifo_mode <= 1'b1;
    offer(8'hA5);
    // Let the offer's release pass an edge before offering again.
    @(posedge clk_sys);
    // Second byte waits while the first is read, then follows it.
    rx_valid <= 1'b1;
    rx_byte <= 8'h3C;
    fetch(8'hA5);
    offer(8'h3C);
    fetch(8'h3C);
    check(8'(fills), 8'h02);
    // A full transmit hold refuses the next write until taken.
    send(8'h5A);
    check({7'h00, tx_valid}, 8'h01);
    check(tx_byte, 8'h5A);
    wr_req <= 1'b1;
    wr_byte <= 8'hC3;
    repeat (10) @(posedge clk_sys);
    check(tx_byte, 8'h5A);
    check({7'h00, pins_if.tx_space_n}, 8'h01);
    tx_take <= 1'b1;
    @(posedge clk_sys);
    tx_take <= 1'b0;
    send(8'hC3);
    check(tx_byte, 8'hC3);
    // Resume, flush and neither, by suspend and wakeup state.
    strobe(1'b1, 1'b1, 2'b10);
    strobe(1'b0, 1'b0, 2'b01);
    strobe(1'b1, 1'b0, 2'b00);
    // Bit-bang: drive a pattern, then release and sample the bus.
    bb_enable <= 1'b1;
    bb_dir <= 8'hFF;
    // The mode register takes one edge to switch to bit-bang.
    @(posedge clk_sys);
    bb_wr_data <= 8'h96;
    bb_wr_stb <= 1'b1;
    @(posedge clk_sys);
    bb_wr_stb <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk_sys);
      seen = seen | !pins_if.pins_updated_n;
    end
    check({7'h00, seen}, 8'h01);
    check(pins_if.port_data, 8'h96);
    bb_dir <= 8'h00;
    repeat (2) @(posedge clk_sys);
    bb_rd_stb <= 1'b1;
    @(posedge clk_sys);
    bb_rd_stb <= 1'b0;
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      seen = seen | pins_sampled_w();
    end
    check({7'h00, seen}, 8'h01);
    check(bb_rd_data, 8'hFF);
    give_verdict();
  end
  // Present level of the pins-sampled output.
  function automatic logic pins_sampled_w();
    return pins_if.pins_sampled;
  endfunction
endmodule
